/* File: rtl/atpg_map.vh */
`ifndef ATPG_MAP_VH
`define ATPG_MAP_VH
// Operation
// (RULE1) Software clears high_perf_mode_one before using test patterns.
// (RULE2) Patterns are selected by writing all three pattern registers.
// (RULE3) In pattern mode the pattern word replaces sampled converter data.
// (RULE4) Pattern data still passes through burst-mode resolution logic.
// (RULE5) Low-resolution periods force discarded pattern LSBs to zero.
// (RULE6) Control register values: 8000, BFFC, 9554, BFFC per pattern.
// (RULE7) First word register values: 0000, 3FFC, 2AA8, 0000 per pattern.
// (RULE8) Second word register values: 0000, 3FFC, 1554, 3FFC per pattern.
// (RULE9) Custom pattern: control bits 15:14 are 1,0; word in bits 13:2.
// (RULE10) Normal operation: set high_perf_mode_one and zero all pattern registers.
// (RULE11) Only the three pattern registers select the pattern.
// (RULE12) Full-speed low resolution keeps rate, only nine MSBs carry data.
// (RULE13) Control bit 15 enables pattern mode; words sit in bits 13:2.
// (RULE14) Toggle patterns alternate two words per sample on both channels.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ATPG_ADDR_MODE     8'h01
`define ATPG_ADDR_CTRL     8'h3C
`define ATPG_ADDR_FIRST    8'h3D
`define ATPG_ADDR_SECOND   8'h3E
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ATPG_PERF_BIT      1
`define ATPG_EN_BIT        15
`define ATPG_WORD_MSB      13
`define ATPG_WORD_LSB      2
`define ATPG_MODE_RESET    16'h0002
`define ATPG_PAT_RESET     16'h0000
`define ATPG_READ_IDLE     16'h0000
`define ATPG_HI_BITS       12
`define ATPG_LO_BITS       9
`endif

/* File: rtl/atpg_lowres.v */
`include "atpg_map.vh"
module atpg_lowres
#(
  parameter WIDTH = `ATPG_HI_BITS,
  parameter KEEP  = `ATPG_LO_BITS
)
(
  input  wire [WIDTH-1:0] word_in,
  input  wire             low_res,
  output wire [WIDTH-1:0] word_out
);
  // ----------------------------------------
  // Resolution mask
  // ----------------------------------------
  // Rate is untouched; only the dropped LSBs are zeroed
  wire [WIDTH-1:0] mask;
  assign mask     = {{KEEP{1'b1}}, {(WIDTH-KEEP){1'b0}}}; // RULE12
  assign word_out = low_res ? (word_in & mask) : word_in; // RULE5
endmodule // atpg_lowres

/* File: rtl/atpg_top.v */
`include "atpg_map.vh"
module atpg_top
#(
  parameter WIDTH = `ATPG_HI_BITS
)
(
  input  wire             clock,
  input  wire             rst_b,
  input  wire             reg_wr,
  input  wire [7:0]       reg_addr,
  input  wire [15:0]      reg_wdata,
  output reg  [15:0]      reg_rdata,
  input  wire [WIDTH-1:0] sample_a,
  input  wire [WIDTH-1:0] sample_b,
  input  wire             low_res,
  output reg  [WIDTH-1:0] out_a,
  output reg  [WIDTH-1:0] out_b,
  output reg              pattern_active
);
  // ----------------------------------------
  // Generator states
  // ----------------------------------------
  // Idle and first both present the first word; only second differs
  localparam [1:0] GEN_IDLE   = 2'b00;
  localparam [1:0] GEN_FIRST  = 2'b01;
  localparam [1:0] GEN_SECOND = 2'b10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // The mode word is only stored; clearing its bit is software's duty
  reg [15:0] perf_mode_word;
  reg [15:0] pattern_control_word;
  reg [15:0] pattern_word_first;
  reg [15:0] pattern_word_second;
  reg [1:0]  gen_state;
  reg [15:0] next_perf_mode_word;
  reg [15:0] next_pattern_control_word;
  reg [15:0] next_pattern_word_first;
  reg [15:0] next_pattern_word_second;
  reg [15:0] next_reg_rdata;
  reg [1:0]  next_gen_state;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // True when the write strobe targets the given offset
  function addr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = wr && (addr == target);
    end
  endfunction

  // Every pattern register keeps its word in bits 13:2
  function [WIDTH-1:0] field;
    input [15:0] r;
    begin
      field = r[`ATPG_WORD_MSB:`ATPG_WORD_LSB]; // RULE13
    end
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Unmapped offsets match no compare, so such writes leave every register alone
  always @*
  begin
    next_perf_mode_word       = perf_mode_word;
    next_pattern_control_word = pattern_control_word;
    next_pattern_word_first   = pattern_word_first;
    next_pattern_word_second  = pattern_word_second;
    if (addr_hit(reg_wr, reg_addr, `ATPG_ADDR_MODE))
    begin
      next_perf_mode_word = reg_wdata;
    end
    if (addr_hit(reg_wr, reg_addr, `ATPG_ADDR_CTRL))
    begin
      next_pattern_control_word = reg_wdata; // RULE11
    end
    if (addr_hit(reg_wr, reg_addr, `ATPG_ADDR_FIRST))
    begin
      next_pattern_word_first = reg_wdata; // RULE9
    end
    if (addr_hit(reg_wr, reg_addr, `ATPG_ADDR_SECOND))
    begin
      next_pattern_word_second = reg_wdata;
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      perf_mode_word       <= `ATPG_MODE_RESET;
      pattern_control_word <= `ATPG_PAT_RESET;
      pattern_word_first   <= `ATPG_PAT_RESET;
      pattern_word_second  <= `ATPG_PAT_RESET;
    end
    else
    begin
      perf_mode_word       <= next_perf_mode_word;
      pattern_control_word <= next_pattern_control_word;
      pattern_word_first   <= next_pattern_word_first;
      pattern_word_second  <= next_pattern_word_second;
    end
  end

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  // Read data is flopped, so it follows reg_addr one edge late
  always @*
  begin
    case (reg_addr)
      `ATPG_ADDR_MODE:   next_reg_rdata = perf_mode_word;
      `ATPG_ADDR_CTRL:   next_reg_rdata = pattern_control_word;
      `ATPG_ADDR_FIRST:  next_reg_rdata = pattern_word_first;
      `ATPG_ADDR_SECOND: next_reg_rdata = pattern_word_second;
      default:           next_reg_rdata = `ATPG_READ_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= `ATPG_READ_IDLE;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------
  // Pattern sequencing
  // ----------------------------------------
  // Enable follows bit 15 alone; the mode bit is not gated here
  wire             enable;
  wire             toggle;
  wire [WIDTH-1:0] word_one;
  wire [WIDTH-1:0] word_two;
  wire [WIDTH-1:0] pat_word;
  wire [WIDTH-1:0] src_a;
  wire [WIDTH-1:0] src_b;
  wire [WIDTH-1:0] res_a;
  wire [WIDTH-1:0] res_b;
  assign enable   = pattern_control_word[`ATPG_EN_BIT]; // RULE13
  assign word_one = field(pattern_word_first);
  assign word_two = field(pattern_word_second);
  // Different words mean toggle; equal words give a steady pattern
  assign toggle   = word_one != word_two;

  // Leaving pattern mode drops to idle, so every run starts on the first word
  always @*
  begin
    next_gen_state = GEN_IDLE;
    if (enable)
    begin
      case (gen_state)
        GEN_IDLE:   next_gen_state = GEN_SECOND;
        GEN_FIRST:  next_gen_state = GEN_SECOND;
        GEN_SECOND: next_gen_state = GEN_FIRST;
        default:    next_gen_state = GEN_IDLE;
      endcase
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gen_state <= GEN_IDLE;
    end
    else
    begin
      gen_state <= next_gen_state; // RULE14
    end
  end

  // ----------------------------------------
  // Substitution and resolution
  // ----------------------------------------
  // One word feeds both channels, so the receiver can compare lanes directly
  assign pat_word = (toggle && (gen_state == GEN_SECOND)) ? word_two
                                                          : word_one; // RULE14
  assign src_a    = enable ? pat_word : sample_a; // RULE3
  assign src_b    = enable ? pat_word : sample_b; // RULE3

  // Each channel has its own burst-mode resolution stage instance
  atpg_lowres #(.WIDTH(WIDTH)) u_lowres_a
  (
    .word_in  (src_a),
    .low_res  (low_res),
    .word_out (res_a)
  ); // RULE4
  atpg_lowres #(.WIDTH(WIDTH)) u_lowres_b
  (
    .word_in  (src_b),
    .low_res  (low_res),
    .word_out (res_b)
  ); // RULE4

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Flopped words give the receiver one clean value per sample
  // Costs one cycle of latency against the raw sample path
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_a          <= {WIDTH{1'b0}};
      out_b          <= {WIDTH{1'b0}};
      pattern_active <= 1'b0;
    end
    else
    begin
      out_a          <= res_a;
      out_b          <= res_b;
      pattern_active <= enable;
    end
  end
endmodule // atpg_top

/* File: verification/atpg_props.sv */
module atpg_props (
  input wire        clock,
  input wire        rst_b,
  input wire        reg_wr,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire [11:0] sample_a,
  input wire [11:0] sample_b,
  input wire        low_res,
  input wire [11:0] out_a,
  input wire [11:0] out_b,
  input wire        pattern_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence word_wr_then_read;
    reg_wr && reg_addr == 8'h3E ##1 !reg_wr && reg_addr == 8'h3E;
  endsequence
  sequence pattern_quiet;
    (!reg_wr && pattern_active && $stable(low_res)) [*5];
  endsequence
  chk_word_readback: assert property (word_wr_then_read
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("pattern word readback");
  chk_pattern_period: assert property (pattern_quiet
    |-> out_a == $past(out_a, 2) && out_b == $past(out_b, 2))
    else $error("pattern period broken");
  chk_enable_copy: assert property (reg_wr && reg_addr == 8'h3C
    |-> ##2 pattern_active == $past(reg_wdata[15], 2)) else $error("enable copy");
  chk_sample_pass: assert property (!pattern_active && $past(rst_b && !low_res)
    |-> out_a == $past(sample_a)) else $error("sample not passed");
  chk_low_zero: assert property ($past(rst_b && low_res)
    |-> out_a[2:0] == 3'h0 && out_b[2:0] == 3'h0) else $error("low bits not zero");
  chk_chan_match: assert property (pattern_active
    |-> out_a == out_b) else $error("channels differ");
endmodule // atpg_props
bind atpg_top atpg_props atpg_props_inst (.*);

/* File: verification/atpg_rx.sv */
module atpg_rx (
  input  wire        clock,
  input  wire [11:0] out_a,
  input  wire [11:0] out_b,
  output reg  [11:0] cap_a,
  output reg  [11:0] cap_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // One word late, so the bench can see two successive samples
  always @(posedge clock)
  begin
    cap_a <= out_a;
    cap_b <= out_b;
  end
endmodule // atpg_rx

/* File: verification/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clock = 0, rst_b = 0, reg_wr = 0, low_res = 0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [15:0] reg_wdata = 16'h0000;
  reg  [11:0] sample_a = 12'h5A3, sample_b = 12'hC3F;
  wire [15:0] reg_rdata;
  wire [11:0] out_a, out_b, cap_a, cap_b;
  wire        pattern_active;
  integer     errors = 0, checks_done = 0, cyc = 0;
  atpg_top atpg_top_inst (.*);
  atpg_rx  atpg_rx_inst (.*);
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cyc += 1;
    if (cyc == 500) summarize;
  end
  task cmp(input [15:0] seen, input [15:0] exp);
    checks_done += 1;
    errors += (seen !== exp);
    if (seen !== exp) $display("unexpected at %0t: %h not %h", $time, seen, exp);
  endtask
  // Waits for a rising edge when entered from a check at the falling edge
  task wr(input [7:0] a, input [15:0] d);
    if (!clock) @(posedge clock);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task settle(input integer n, input lr);
    reg_wr <= 0;
    low_res <= lr;
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task t_toggle;
    wr(8'h01, 16'h0000);
    wr(8'h3C, 16'h9554);
    wr(8'h3D, 16'h2AA8);
    wr(8'h3E, 16'h1554);
    settle(4, 0);
    cmp(reg_rdata, 16'h1554);
    cmp(pattern_active, 16'h0001);
    cmp(out_a ^ cap_a, 16'h0FFF);
    cmp(out_b ^ cap_b, 16'h0FFF);
    @(posedge clock);
    settle(3, 1);
    cmp(out_a ^ cap_a, 16'h0FF8);
  endtask
  task t_custom_normal;
    wr(8'h3C, 16'h8000);
    wr(8'h3D, 16'h270C);
    wr(8'h3E, 16'h270C);
    settle(4, 1);
    cmp(cap_b, 16'h09C0);
    @(posedge clock);
    settle(3, 0);
    cmp(cap_a, 16'h09C3);
    wr(8'h01, 16'h0002);
    wr(8'h3C, 16'h0000);
    wr(8'h3D, 16'h0000);
    wr(8'h3E, 16'h0000);
    wr(8'h02, 16'hFFFF);
    settle(4, 0);
    cmp(reg_rdata, 16'h0000);
    cmp(pattern_active, 16'h0000);
    cmp(cap_b, 16'h0C3F);
  endtask
  task summarize;
    errors += (cyc >= 500);
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    t_toggle;
    t_custom_normal;
    summarize;
  end
endmodule // tb_top
